// ==== rtl/hies_defines.svh ====
// register indices, byte addresses, field positions and reset values
`ifndef HIES_DEFINES_SVH
`define HIES_DEFINES_SVH

`define HIES_IDX_ERR 8'h12
`define HIES_IDX_RXVEC 8'h24
`define HIES_IDX_TXVEC 8'h26
`define HIES_IDX_MASK 8'h2A
`define HIES_ADDR_ERR {2'b00, `HIES_IDX_ERR, 2'b00}
`define HIES_ADDR_RXVEC {2'b00, `HIES_IDX_RXVEC, 2'b00}
`define HIES_ADDR_TXVEC {2'b00, `HIES_IDX_TXVEC, 2'b00}
`define HIES_ADDR_MASK {2'b00, `HIES_IDX_MASK, 2'b00}

`define HIES_ERR_RESET 16'h0000
`define HIES_VEC_RESET 6'h00
`define HIES_MASK_RESET 8'h00
`define HIES_ERR_IMPL 16'h0FDB

`define HIES_BIT_FRAME_LOST 0
`define HIES_BIT_ILLEGAL_RECONFIG 1
`define HIES_BIT_BUFFER_BUSY 3
`define HIES_BIT_DOUBLE_LOCK 4
`define HIES_BIT_RX_LOCK 6
`define HIES_BIT_TX_LOCK 7
`define HIES_BIT_QUEUE_LOCK 8
`define HIES_BIT_EMPTY_QUEUE 9
`define HIES_BIT_UNLOCKED 10
`define HIES_BIT_DYN_LENGTH 11

`define HIES_NUM_BUFFERS 59

`endif

// ==== rtl/hies_pkg.sv ====
// types shared by the host interface error and status block
package hies_pkg;
    typedef logic [15:0] hies_reg_type;
    typedef logic [5:0] hies_vec_type;
    typedef logic [7:0] hies_mask_type;
    typedef logic [58:0] hies_buf_type;
endpackage : hies_pkg

// ==== rtl/hies_top.sv ====
// host interface error register, buffer interrupt vectors and slot counter mask
//
// Overview of operation
// - eight mask bits gate counter increment flags onto slot status summary interrupt
// - receive vector holds lowest receive buffer index with flag and enable set
// - any buffer flag change refreshes both vectors one microtick later
// - receive vector reads zero when no receive buffer is flagged and enabled
// - transmit vector holds lowest transmit buffer index with flag and enable set
// - transmit vector reads zero when no transmit buffer is flagged and enabled
// - both vectors clear on reset and on leaving configuration state
// - writing one clears an error bit, zero leaves it; conditions set it again
// - a device set in the same cycle as a host clear wins
// - reset clears the whole error register
// - recorded errors raise interrupt only when enabled; operation continues unchanged
// - frame lost flag bit 0 when locked receive buffer gets two valid frames
// - illegal dynamic to static reconfiguration ignored, flag bit 1
// - lock of device-held buffer refused, busy flag bit 3
// - lock of controller half of double buffer refused, flag bit 4
// - second receive buffer lock refused, flag bit 6
// - second transmit buffer lock refused, flag bit 7
// - queue buffer lock other than through buffer 0 refused, flag bit 8
// - lock of empty receive queue refused, flag bit 9
// - unlocked buffer access ignored and reads zero, flag bit 10
// - oversized dynamic payload length ignored, flag bit 11
`timescale 1ns/1ps
`include "hies_defines.svh"

module hies_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] counter_increment_flags,
    output logic slot_status_summary_irq,
    input wire hies_pkg::hies_buf_type buffer_irq_flag,
    input wire hies_pkg::hies_buf_type buffer_irq_enable,
    input wire hies_pkg::hies_buf_type buffer_is_transmit,
    input wire logic microtick_tick,
    input wire logic in_config_state,
    input wire logic host_error_irq_enable,
    input wire logic frame_lost_event,
    input wire logic illegal_reconfig_event,
    input wire logic buffer_busy_event,
    input wire logic double_buffer_lock_event,
    input wire logic receive_lock_event,
    input wire logic transmit_lock_event,
    input wire logic queue_buffer_lock_event,
    input wire logic empty_queue_lock_event,
    input wire logic unlocked_access_event,
    input wire logic dynamic_length_event,
    output logic host_error_pending,
    output logic host_error_irq
);

    // lowest set bit index; zero when nothing is set
    function automatic hies_pkg::hies_vec_type hies_lowest(input hies_pkg::hies_buf_type v);
        hies_pkg::hies_vec_type idx;
        idx = `HIES_VEC_RESET;
        for (int i = `HIES_NUM_BUFFERS - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 6'(i);
            end
        end
        return idx;
    endfunction : hies_lowest

    hies_pkg::hies_reg_type err_r;
    hies_pkg::hies_reg_type err_nxt;
    hies_pkg::hies_vec_type rx_vec_r;
    hies_pkg::hies_vec_type tx_vec_r;
    hies_pkg::hies_mask_type mask_r;
    hies_pkg::hies_buf_type flag_prev_r;
    hies_pkg::hies_buf_type ena_prev_r;
    logic pending_r;
    logic cfg_prev_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic summary_r;
    logic err_any_r;
    logic err_irq_r;

    // bus decode; one wait state so read data comes from a flop
    wire access_w = psel & penable;
    wire first_w = access_w & ~pready_r;
    wire done_w = access_w & pready_r;
    wire sel_err_w = (paddr[11:0] == `HIES_ADDR_ERR);
    wire sel_rx_w = (paddr[11:0] == `HIES_ADDR_RXVEC);
    wire sel_tx_w = (paddr[11:0] == `HIES_ADDR_TXVEC);
    wire sel_mask_w = (paddr[11:0] == `HIES_ADDR_MASK);
    wire mapped_w = sel_err_w | sel_rx_w | sel_tx_w | sel_mask_w;
    wire wr_err_w = done_w & pwrite & sel_err_w;
    wire wr_mask_w = done_w & pwrite & sel_mask_w;

    // reserved positions always read zero
    wire [31:0] rd_mux_w = sel_err_w ? {16'h0000, err_r & `HIES_ERR_IMPL} :
                           sel_rx_w ? {26'h000_0000, rx_vec_r} :
                           sel_tx_w ? {26'h000_0000, tx_vec_r} :
                           sel_mask_w ? {24'h00_0000, mask_r} : 32'h0000_0000;

    // buffer vector candidates
    wire [58:0] rx_cand_w = buffer_irq_flag & buffer_irq_enable & ~buffer_is_transmit;
    wire [58:0] tx_cand_w = buffer_irq_flag & buffer_irq_enable & buffer_is_transmit;
    wire [5:0] rx_low_w = hies_lowest(rx_cand_w);
    wire [5:0] tx_low_w = hies_lowest(tx_cand_w);
    wire change_w = (buffer_irq_flag != flag_prev_r) | (buffer_irq_enable != ena_prev_r);
    wire refresh_w = microtick_tick & pending_r;
    wire leave_cfg_w = cfg_prev_r & ~in_config_state;
    wire pending_nxt = change_w | (pending_r & ~microtick_tick);

    // error condition pulses collected into their bit positions
    wire [15:0] err_set_w = {
        4'h0,
        dynamic_length_event,
        unlocked_access_event,
        empty_queue_lock_event,
        queue_buffer_lock_event,
        transmit_lock_event,
        receive_lock_event,
        1'b0,
        double_buffer_lock_event,
        buffer_busy_event,
        1'b0,
        illegal_reconfig_event,
        frame_lost_event
    };
    wire [15:0] err_clr_w = wr_err_w ? pwdata[15:0] : 16'h0000;

    // set beats clear so a coincident event is never lost
    assign err_nxt = ((err_r & ~err_clr_w) | err_set_w) & `HIES_ERR_IMPL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_r <= `HIES_ERR_RESET;
        end else begin
            err_r <= err_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= `HIES_MASK_RESET;
        end else if (wr_mask_w) begin
            mask_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_vec_r <= `HIES_VEC_RESET;
            tx_vec_r <= `HIES_VEC_RESET;
        end else if (leave_cfg_w) begin
            rx_vec_r <= `HIES_VEC_RESET;
            tx_vec_r <= `HIES_VEC_RESET;
        end else if (refresh_w) begin
            rx_vec_r <= rx_low_w;
            tx_vec_r <= tx_low_w;
        end
    end

    // a change landing on the tick stays pending for the next refresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_r <= 1'b0;
            flag_prev_r <= '0;
            ena_prev_r <= '0;
            cfg_prev_r <= 1'b0;
        end else begin
            pending_r <= pending_nxt;
            flag_prev_r <= buffer_irq_flag;
            ena_prev_r <= buffer_irq_enable;
            cfg_prev_r <= in_config_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            summary_r <= 1'b0;
            err_any_r <= 1'b0;
            err_irq_r <= 1'b0;
        end else begin
            summary_r <= |(counter_increment_flags & mask_r);
            err_any_r <= |err_r;
            err_irq_r <= (|err_r) & host_error_irq_enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= first_w;
            if (first_w) begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_mux_w;
                pslverr_r <= ~mapped_w;
            end else begin
                prdata_r <= 32'h0000_0000;
                pslverr_r <= 1'b0;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign slot_status_summary_irq = summary_r;
    assign host_error_pending = err_any_r;
    assign host_error_irq = err_irq_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_MASK_GATE: assert property (
        ##1 (slot_status_summary_irq == $past(|(counter_increment_flags & mask_r))))
        else $error("summary interrupt does not follow masked flags");

    AST_RX_INDEX: assert property (
        (refresh_w && !leave_cfg_w && rx_cand_w != '0) |=>
        ((($past(rx_cand_w) >> rx_vec_r) & 59'd1) == 59'd1) &&
        (($past(rx_cand_w) & ((59'd1 << rx_vec_r) - 59'd1)) == '0))
        else $error("receive vector is not the lowest flagged buffer");

    AST_TX_INDEX: assert property (
        (refresh_w && !leave_cfg_w && tx_cand_w != '0) |=>
        ((($past(tx_cand_w) >> tx_vec_r) & 59'd1) == 59'd1) &&
        (($past(tx_cand_w) & ((59'd1 << tx_vec_r) - 59'd1)) == '0))
        else $error("transmit vector is not the lowest flagged buffer");

    AST_VEC_HOLD: assert property (
        (!refresh_w && !leave_cfg_w) |=> $stable(rx_vec_r) && $stable(tx_vec_r))
        else $error("vector changed without a microtick refresh");

    AST_CHANGE_PENDS: assert property (
        (change_w && !microtick_tick) |=> pending_r)
        else $error("buffer flag change did not schedule a refresh");

    AST_RX_ZERO: assert property (
        (refresh_w && !leave_cfg_w && rx_cand_w == '0) |=> rx_vec_r == 6'h00)
        else $error("receive vector not zero with no candidates");

    AST_TX_ZERO: assert property (
        (refresh_w && !leave_cfg_w && tx_cand_w == '0) |=> tx_vec_r == 6'h00)
        else $error("transmit vector not zero with no candidates");

    AST_LEAVE_CLR: assert property (
        $fell(in_config_state) |=> (rx_vec_r == 6'h00) && (tx_vec_r == 6'h00))
        else $error("vectors not cleared on leaving configuration");

    AST_W1C: assert property (
        (wr_err_w && pwdata[0] && !frame_lost_event) |=> !err_r[0])
        else $error("write one did not clear frame lost flag");

    AST_SET_WINS: assert property (
        (err_set_w != 16'h0000) |=>
        ((err_r & $past(err_set_w)) == $past(err_set_w)))
        else $error("device set lost against host clear");

    AST_RSVD: assert property (
        (err_r & ~`HIES_ERR_IMPL) == 16'h0000)
        else $error("reserved error bit is set");

    AST_ERR_IRQ: assert property (
        (err_r != 16'h0000 && host_error_irq_enable) |=> host_error_irq)
        else $error("enabled error did not raise interrupt");

    AST_ERR_NO_IRQ: assert property (
        !host_error_irq_enable |=> !host_error_irq)
        else $error("error interrupt raised while disabled");

    AST_ERR_PEND: assert property (
        ##1 (host_error_pending == $past(|err_r)))
        else $error("error pending does not follow error register");

    AST_ERR_IRQ_PEND: assert property (
        host_error_irq |-> host_error_pending)
        else $error("error interrupt without pending error");

    AST_W0_KEEPS: assert property (
        (wr_err_w && (err_r & ~pwdata[15:0]) != 16'h0000) |=>
        ((err_r & $past(err_r & ~pwdata[15:0])) == $past(err_r & ~pwdata[15:0])))
        else $error("writing zero changed an error bit");

    AST_W1C_ANY: assert property (
        (wr_err_w && (pwdata[15:0] & ~err_set_w) != 16'h0000) |=>
        ((err_r & $past(pwdata[15:0] & ~err_set_w)) == 16'h0000))
        else $error("writing one did not clear an error bit");

    AST_NO_SPURIOUS: assert property (
        (err_set_w == 16'h0000) |=> ((err_r & ~$past(err_r)) == 16'h0000))
        else $error("error bit set without its condition");

    AST_CLR_NEEDS_WRITE: assert property (
        !wr_err_w |=> (($past(err_r) & ~err_r) == 16'h0000))
        else $error("error bit cleared without a host write");

    // each condition lands in its own bit one cycle later
    AST_SET_FRAME_LOST: assert property (
        frame_lost_event |=> err_r[`HIES_BIT_FRAME_LOST])
        else $error("frame lost condition not recorded");

    AST_SET_ILLEGAL_RECONFIG: assert property (
        illegal_reconfig_event |=> err_r[`HIES_BIT_ILLEGAL_RECONFIG])
        else $error("illegal reconfiguration not recorded");

    AST_SET_BUFFER_BUSY: assert property (
        buffer_busy_event |=> err_r[`HIES_BIT_BUFFER_BUSY])
        else $error("buffer busy not recorded");

    AST_SET_DOUBLE_LOCK: assert property (
        double_buffer_lock_event |=> err_r[`HIES_BIT_DOUBLE_LOCK])
        else $error("double buffer lock error not recorded");

    AST_SET_RX_LOCK: assert property (
        receive_lock_event |=> err_r[`HIES_BIT_RX_LOCK])
        else $error("receive lock error not recorded");

    AST_SET_TX_LOCK: assert property (
        transmit_lock_event |=> err_r[`HIES_BIT_TX_LOCK])
        else $error("transmit lock error not recorded");

    AST_SET_QUEUE_LOCK: assert property (
        queue_buffer_lock_event |=> err_r[`HIES_BIT_QUEUE_LOCK])
        else $error("queue buffer lock error not recorded");

    AST_SET_EMPTY_QUEUE: assert property (
        empty_queue_lock_event |=> err_r[`HIES_BIT_EMPTY_QUEUE])
        else $error("empty queue lock error not recorded");

    AST_SET_UNLOCKED: assert property (
        unlocked_access_event |=> err_r[`HIES_BIT_UNLOCKED])
        else $error("unlocked access error not recorded");

    AST_SET_DYN_LENGTH: assert property (
        dynamic_length_event |=> err_r[`HIES_BIT_DYN_LENGTH])
        else $error("dynamic length error not recorded");

    AST_RD_ERR_RSVD: assert property (
        (pready && sel_err_w) |->
        ((prdata[15:0] & ~`HIES_ERR_IMPL) == 16'h0000) && (prdata[31:16] == 16'h0000))
        else $error("reserved error register bits read nonzero");

    AST_RD_VEC_RSVD: assert property (
        (pready && (sel_rx_w || sel_tx_w)) |-> (prdata[31:6] == '0))
        else $error("reserved vector register bits read nonzero");

    AST_RD_MASK_RSVD: assert property (
        (pready && sel_mask_w) |-> (prdata[31:8] == '0))
        else $error("reserved mask register bits read nonzero");

    AST_PSLVERR_ZERO: assert property (
        (pready && pslverr) |-> (prdata == 32'h0000_0000))
        else $error("refused access returned nonzero data");

    AST_MASK_WRITE: assert property (
        wr_mask_w |=> (mask_r == $past(pwdata[7:0])))
        else $error("mask write did not land");

    AST_MASK_HOLD: assert property (
        !wr_mask_w |=> $stable(mask_r))
        else $error("mask changed without a write");

    AST_SUMMARY_MASKED: assert property (
        (mask_r == 8'h00) |=> !slot_status_summary_irq)
        else $error("summary interrupt raised with all flags masked");

    AST_PENDING_CLEARS: assert property (
        (microtick_tick && !change_w) |=> !pending_r)
        else $error("refresh request not consumed by the microtick");

endmodule : hies_top

// ==== sim/hies_host.sv ====
// apb host model that issues register reads and writes
`timescale 1ns/1ps
module hies_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // request held until pready is sampled high at a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines flip so a stale value cannot pass
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : hies_host

// ==== sim/test_hies_top.sv ====
// self-checking bench for the error register, buffer vectors and counter mask
`timescale 1ns/1ps
`include "hies_defines.svh"
module test_hies_top;
    typedef struct {int a; int b; logic dis; logic [5:0] erx; logic [5:0] etx;} hies_row_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tick, cfg, irq_en, err;
    logic sum_irq, pend, eirq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] incr;
    logic [9:0] ev;
    hies_pkg::hies_buf_type flg, ena, trn;
    int errors, compares;
    int pos[10] = '{0, 1, 3, 4, 6, 7, 8, 9, 10, 11};
    // buffers 32 and up are transmit; dis masks the enable of buffer a
    hies_row_type rows[6] = '{'{5, 40, 1'b0, 6'h05, 6'h28}, '{9, 3, 1'b0, 6'h03, 6'h00},
        '{58, 33, 1'b0, 6'h00, 6'h21}, '{32, 0, 1'b0, 6'h00, 6'h20},
        '{2, 7, 1'b1, 6'h07, 6'h00}, '{45, 36, 1'b1, 6'h00, 6'h24}};

    hies_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .counter_increment_flags(incr), .slot_status_summary_irq(sum_irq),
        .buffer_irq_flag(flg), .buffer_irq_enable(ena), .buffer_is_transmit(trn),
        .microtick_tick(tick), .in_config_state(cfg), .host_error_irq_enable(irq_en),
        .frame_lost_event(ev[0]), .illegal_reconfig_event(ev[1]), .buffer_busy_event(ev[2]),
        .double_buffer_lock_event(ev[3]), .receive_lock_event(ev[4]),
        .transmit_lock_event(ev[5]), .queue_buffer_lock_event(ev[6]),
        .empty_queue_lock_event(ev[7]), .unlocked_access_event(ev[8]),
        .dynamic_length_event(ev[9]), .host_error_pending(pend), .host_error_irq(eirq));
    hies_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic complete_run;
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        i_host.xfer(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd, exp);
    endtask : rdc

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, rd, err);
    endtask : wr

    // besides the clears on reset and on leaving configuration, vectors only move on a microtick after the flag or enable change was seen
    task automatic refresh;
        step(2);
        tick <= 1'b1;
        step(1);
        tick <= 1'b0;
        step(2);
    endtask : refresh

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        step(20000);
        errors++;
        complete_run();
    end

    initial begin
        presetn = 1'b0;
        {tick, irq_en, incr, ev, flg, ena} = '0;
        cfg = 1'b1;
        trn = 59'h7FF_FFFF_0000_0000;
        step(6);
        presetn <= 1'b1;
        rdc(`HIES_ADDR_MASK, 32'h0000_0000);
        cfg <= 1'b0;
        foreach (rows[i]) begin
            @(posedge pclk);
            flg <= (59'h1 << rows[i].a) | (59'h1 << rows[i].b);
            ena <= ~({58'h0, rows[i].dis} << rows[i].a);
            refresh();
            rdc(`HIES_ADDR_RXVEC, 32'(rows[i].erx));
            rdc(`HIES_ADDR_TXVEC, 32'(rows[i].etx));
        end
        flg <= 59'h1 << 12;
        step(4);
        rdc(`HIES_ADDR_TXVEC, 32'h0000_0024);
        refresh();
        rdc(`HIES_ADDR_RXVEC, 32'h0000_000C);
        cfg <= 1'b1;
        step(2);
        cfg <= 1'b0;
        step(3);
        rdc(`HIES_ADDR_RXVEC, 32'h0000_0000);
        incr <= 8'hA5;
        wr(`HIES_ADDR_MASK, 32'h0000_000F);
        step(2);
        chk(32'(sum_irq), 32'h0000_0001);
        wr(`HIES_ADDR_MASK, 32'hFFFF_FF5A);
        rdc(`HIES_ADDR_MASK, 32'h0000_005A);
        chk(32'(sum_irq), 32'h0000_0000);
        i_host.xfer(1'b0, 12'h004, 32'h0000_0000, rd, err);
        chk(32'(err), 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        for (int i = 0; i < 10; i++) begin
            irq_en <= i[0];
            ev <= 10'h001 << i;
            step(1);
            ev <= 10'h000;
            step(2);
            chk(32'({pend, eirq}), 32'({1'b1, i[0]}));
            rdc(`HIES_ADDR_ERR, 32'h1 << pos[i]);
            wr(`HIES_ADDR_ERR, ~(32'h1 << pos[i]));
            rdc(`HIES_ADDR_ERR, 32'h1 << pos[i]);
            wr(`HIES_ADDR_ERR, 32'h1 << pos[i]);
            rdc(`HIES_ADDR_ERR, 32'h0000_0000);
        end
        // event held through the clearing write so both meet at one edge
        ev <= 10'h200;
        wr(`HIES_ADDR_ERR, 32'h0000_0800);
        ev <= 10'h000;
        rdc(`HIES_ADDR_ERR, 32'h0000_0800);
        // load a nonzero vector so the reset below has something to clear
        ena <= ~59'h0;
        refresh();
        rdc(`HIES_ADDR_RXVEC, 32'h0000_000C);
        presetn <= 1'b0;
        step(2);
        presetn <= 1'b1;
        rdc(`HIES_ADDR_ERR, 32'h0000_0000);
        rdc(`HIES_ADDR_RXVEC, 32'h0000_0000);
        complete_run();
    end
endmodule : test_hies_top
